// ==== adcw_map.vh ====
`ifndef ADCW_MAP_VH
`define ADCW_MAP_VH
// resolution select codes
`define ADCW_RES_12          2'h0
`define ADCW_RES_16          2'h1
`define ADCW_RES_10          2'h2
`define ADCW_RES_8           2'h3
// conversion styles
`define ADCW_MODE_SINGLE     2'h0
`define ADCW_MODE_FREE       2'h1
`define ADCW_MODE_SCAN       2'h2
// window monitor modes
`define ADCW_WIN_OFF         3'h0
`define ADCW_WIN_ABOVE       3'h1
`define ADCW_WIN_BELOW       3'h2
`define ADCW_WIN_INSIDE      3'h3
`define ADCW_WIN_OUTSIDE     3'h4
// sizes
`define ADCW_NATIVE_BITS     12
`define ADCW_RESULT_BITS     16
`define ADCW_MUXPOS_BITS     5
`define ADCW_MUXNEG_BITS     5
`define ADCW_REFSEL_BITS     4
`define ADCW_MUXPOS_MAX      5'h18
`define ADCW_MUXNEG_MAX      5'h09
// timing: conversion clock = system clock, 200 MHz, 350 ksps => 572 cycles per sample
`define ADCW_CLK_MHZ         200
`define ADCW_RATE_KSPS       350
`define ADCW_SAMPLE_CYC      ((`ADCW_CLK_MHZ * 1000 + `ADCW_RATE_KSPS - 1) / `ADCW_RATE_KSPS)
// flag positions
`define ADCW_FLG_RESULT_READY_FLAG      0
`define ADCW_FLG_OVERRUN     1
`define ADCW_FLG_WINMON      2
`define ADCW_FLG_W           3
// trim reset value
`define ADCW_TRIM_RST        11'h000
`endif

// ==== adcw_cdc_word.v ====
`timescale 1ns/10ps
// ----------------------------------------
// two-stage capture of a configuration word
// ----------------------------------------
module adcw_cdc_word #(
   parameter W = 8
) (
   input  wire         clk_sys,
   input  wire         rst_n,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_r;                        // first stage, read only by q
   // sync chain; words must be held stable for two edges
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= {W{1'b0}};
         q      <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // adcw_cdc_word

// ==== adcw_ctrl.v ====
`timescale 1ns/10ps
`include "adcw_map.vh"
// Overview of operation
// - 12-bit native results, up to 350ksps
// - width 8, 10 or 12 bits, shorter conversion
// - left or right justified result
// - signed differential or unsigned single-ended results
// - start by software command or event
// - exactly one event start input
// - single, free-running and pin-scan modes
// - hardware window compare on chosen channel
// - DMA request on conversion complete
// - accumulate with decimation to 16 bits
// - hardware gain and offset correction
// - four-bit reference select
// - 25 positive, 10 negative mux sources
// - keep converting in low power clocked
// - interrupts wake, events do not
// - sync config writes into conversion domain
// - halt in debug unless forced run
// - write protect all but flag register and start command
// - protection lifted in debug halt, external debugger
// - soft reset clears all but debug control
// - new result overwrites, unread sets overrun
// - result width defaults to twelve bits
module adcw_ctrl (
   input  wire        clk_sys,
   input  wire        rst_n,
   // configuration (held by caller, written under wr_cfg)
   input  wire        wr_cfg,         // write strobe for all config fields except debug_run_ctrl, which takes wr_dbg
   input  wire        enable,
   input  wire [1:0]  res_sel,
   input  wire        left_adj,
   input  wire        diff_mode,
   input  wire [1:0]  conv_mode,
   input  wire [4:0]  mux_pos,
   input  wire [4:0]  mux_neg,
   input  wire [4:0]  scan_count,     // extra inputs stepped in scan
   input  wire [3:0]  ref_sel,
   input  wire [2:0]  avg_log2,       // 1..128 accumulated samples
   input  wire [11:0] gain_corr,      // 1.11 fixed point
   input  wire [11:0] offset_corr,
   input  wire        corr_en,
   input  wire [2:0]  win_mode,
   input  wire [4:0]  win_chan,
   input  wire [15:0] win_lo,
   input  wire [15:0] win_hi,
   input  wire [10:0] trim_val,       // bias and linearity_trim_value
   input  wire [2:0]  irq_en,
   input  wire        debug_run_ctrl,
   input  wire        wr_dbg,
   input  wire        protect_on,     // from access_protect_unit
   input  wire        cpu_halted,
   input  wire        cpu_rst_ext,
   input  wire        ext_dbg_acc,
   // commands
   input  wire        start_cmd,
   input  wire        start_evt,      // from event_router
   input  wire        soft_reset_cmd,
   input  wire [2:0]  flag_clr,       // irq_flag_reg write-one-to-clear
   input  wire        result_rd,
   // analog core
   input  wire [11:0] ana_data,
   output reg         ana_sample_r,
   output reg  [4:0]  ana_pos_r,
   output reg  [4:0]  ana_neg_r,
   output reg  [3:0]  ana_ref_r,
   output reg  [10:0] ana_trim_r,
   // results and status
   output reg  [15:0] result_r,
   output reg  [2:0]  irq_flag_reg_r,
   output reg         irq_r,
   output reg         dma_req_r,
   output reg         evt_result_ready_flag_r,
   output reg         wr_refused_r,
   output reg         busy_r,
   output reg         dbg_run_r
);
   // ----------------------------------------
   // write protection and accepted config
   // ----------------------------------------
   wire prot_act = protect_on & ~cpu_halted & ~cpu_rst_ext & ~ext_dbg_acc;
   wire cfg_ok   = wr_cfg & ~prot_act;
   reg  [92:0] cfg_r;                                 // latched config word
   reg  [2:0]  ien_r;
   reg         en_r;
   wire [92:0] cfg_in = {res_sel, left_adj, diff_mode, conv_mode, mux_pos, mux_neg,
                         scan_count, ref_sel, avg_log2, gain_corr, offset_corr,
                         corr_en, win_mode, win_chan, win_lo, win_hi};
   // config capture; flags register is never protected
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r        <= 93'h0;       // res_sel 0 = twelve bits
         ien_r        <= 3'h0;
         en_r         <= 1'b0;
         ana_trim_r   <= `ADCW_TRIM_RST;
         dbg_run_r    <= 1'b0;
         wr_refused_r <= 1'b0;
      end else begin
         wr_refused_r <= wr_cfg & prot_act;
         if (wr_dbg && !prot_act)
            dbg_run_r <= debug_run_ctrl;            // survives soft reset
         if (soft_reset_cmd && !prot_act) begin
            cfg_r      <= 93'h0;
            ien_r      <= 3'h0;
            en_r       <= 1'b0;
            ana_trim_r <= `ADCW_TRIM_RST;
         end else if (cfg_ok) begin
            cfg_r      <= cfg_in;
            ien_r      <= irq_en;
            en_r       <= enable;
            ana_trim_r <= trim_val;                  // software-loaded trim
         end
      end
   end
   // ----------------------------------------
   // crossing into conversion domain
   // ----------------------------------------
   wire [93:0] cs;                                   // synchronised enable and config
   // enable travels with its config so no run starts on stale settings
   adcw_cdc_word #(.W(94)) u_cfg_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({en_r, cfg_r}),
      .q       (cs)
   );
   wire        s_en    = cs[93];
   wire [1:0]  s_res   = cs[92:91];
   wire        s_left  = cs[90];
   wire        s_diff  = cs[89];
   wire [1:0]  s_mode  = cs[88:87];
   wire [4:0]  s_pos   = cs[86:82];
   wire [4:0]  s_neg   = cs[81:77];
   wire [4:0]  s_scan  = cs[76:72];
   wire [3:0]  s_ref   = cs[71:68];
   wire [2:0]  s_avg   = cs[67:65];
   wire [11:0] s_gain  = cs[64:53];
   wire [11:0] s_off   = cs[52:41];
   wire        s_corr  = cs[40];
   wire [2:0]  s_wmode = cs[39:37];
   wire [4:0]  s_wch   = cs[36:32];
   wire [15:0] s_wlo   = cs[31:16];
   wire [15:0] s_whi   = cs[15:0];
   // ----------------------------------------
   // sequencer: one-hot states
   // ----------------------------------------
   localparam ST_IDLE = 3'b001;
   localparam ST_CONV = 3'b010;
   localparam ST_DONE = 3'b100;
   reg  [2:0]  st_r;
   reg  [9:0]  cyc_r;                                // cycles into conversion
   reg  [6:0]  acc_n_r;                              // samples accumulated
   reg  [18:0] acc_r;                                // sum of up to 128 samples
   reg  [4:0]  scan_i_r;                             // scan step
   reg         pend_r;                               // trigger waiting
   wire halted  = cpu_halted & ~dbg_run_r;
   wire trig    = start_cmd | start_evt;
   // narrower results need fewer cycles (bits/12 of the sample period)
   wire [9:0] conv_len = (s_res == `ADCW_RES_8)  ? 10'd381 :
                         (s_res == `ADCW_RES_10) ? 10'd476 : 10'd571;
   wire [6:0] avg_tgt  = (s_res == `ADCW_RES_16) ? (7'h1 << s_avg) - 7'h1 : 7'h0;
   wire [4:0] cur_pos  = s_pos + scan_i_r;
   // sequencer; runs on whatever clock remains in sleep
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_IDLE; cyc_r <= 10'h0; acc_n_r <= 7'h0; acc_r <= 19'h0;
         scan_i_r <= 5'h0; pend_r <= 1'b0; ana_sample_r <= 1'b0; busy_r <= 1'b0;
      end else if (!s_en) begin
         st_r <= ST_IDLE; pend_r <= 1'b0; acc_n_r <= 7'h0; acc_r <= 19'h0;
         scan_i_r <= 5'h0; ana_sample_r <= 1'b0; busy_r <= 1'b0;
      end else if (!halted) begin
         if (trig) pend_r <= 1'b1;
         ana_sample_r <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (pend_r || trig || s_mode == `ADCW_MODE_FREE) begin
                  st_r <= ST_CONV; cyc_r <= 10'h0; pend_r <= 1'b0;
                  ana_sample_r <= 1'b1; busy_r <= 1'b1;
               end
            end
            ST_CONV: begin
               cyc_r <= cyc_r + 10'h1;
               if (cyc_r == conv_len - 10'h1) begin
                  acc_r <= acc_r + {7'h0, ana_data};
                  st_r  <= ST_DONE;
               end
            end
            ST_DONE: begin
               if (acc_n_r != avg_tgt) begin
                  acc_n_r <= acc_n_r + 7'h1;
                  st_r <= ST_CONV; cyc_r <= 10'h0; ana_sample_r <= 1'b1;
               end else begin
                  acc_n_r <= 7'h0; acc_r <= 19'h0;
                  if (s_mode == `ADCW_MODE_SCAN && scan_i_r != s_scan) begin
                     scan_i_r <= scan_i_r + 5'h1;
                     st_r <= ST_CONV; cyc_r <= 10'h0; ana_sample_r <= 1'b1;
                  end else begin
                     scan_i_r <= 5'h0; st_r <= ST_IDLE; busy_r <= 1'b0;
                  end
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // result formatting
   // ----------------------------------------
   wire        fin    = (st_r == ST_DONE) && (acc_n_r == avg_tgt) && s_en && !halted;
   wire [18:0] dec    = acc_r >> ((s_avg > 3'd4) ? (s_avg - 3'd4) : 3'd0);
   wire [15:0] raw    = (s_res == `ADCW_RES_16) ? dec[15:0] :
                        (s_res == `ADCW_RES_10) ? {6'h0, acc_r[11:2]} :
                        (s_res == `ADCW_RES_8)  ? {8'h0, acc_r[11:4]} : {4'h0, acc_r[11:0]};
   // differential: offset-binary to two's complement
   wire [15:0] msb_m  = (s_res == `ADCW_RES_8)  ? 16'h0080 : (s_res == `ADCW_RES_10) ? 16'h0200 :
                        (s_res == `ADCW_RES_12) ? 16'h0800 : 16'h8000;
   wire [15:0] top_m  = (s_res == `ADCW_RES_8)  ? 16'hff80 : (s_res == `ADCW_RES_10) ? 16'hfe00 :
                        (s_res == `ADCW_RES_12) ? 16'hf800 : 16'h8000;
   wire [15:0] flip   = raw ^ msb_m;
   // sign extended so the gain product and left shift see a true signed word
   wire [15:0] sgn    = s_diff ? ((|(flip & msb_m)) ? (flip | top_m) : flip) : raw;
   wire [27:0] prod   = {{12{sgn[15] & s_diff}}, sgn} * {16'h0, s_gain};
   wire [15:0] corr   = s_corr ? (prod[26:11] - {{4{s_off[11]}}, s_off}) : sgn;
   wire [3:0]  lsh    = (s_res == `ADCW_RES_8) ? 4'd8 : (s_res == `ADCW_RES_10) ? 4'd6 :
                        (s_res == `ADCW_RES_12) ? 4'd4 : 4'd0;
   wire [15:0] fmt    = s_left ? (corr << lsh) : corr;
   // window test on the selected channel
   wire win_hit = (cur_pos == s_wch) &&
                  ((s_wmode == `ADCW_WIN_ABOVE)   ? (corr > s_wlo) :
                   (s_wmode == `ADCW_WIN_BELOW)   ? (corr < s_wlo) :
                   (s_wmode == `ADCW_WIN_INSIDE)  ? (corr > s_wlo && corr < s_whi) :
                   (s_wmode == `ADCW_WIN_OUTSIDE) ? (corr < s_wlo || corr > s_whi) : 1'b0);
   // ----------------------------------------
   // result, flags, requests
   // ----------------------------------------
   reg unread_r;
   wire [2:0] set_v = {fin & win_hit, fin & unread_r & ~result_rd, fin};
   // set beats clear on the same edge
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         result_r <= 16'h0; irq_flag_reg_r <= 3'h0; irq_r <= 1'b0; dma_req_r <= 1'b0;
         evt_result_ready_flag_r <= 1'b0; unread_r <= 1'b0;
         ana_pos_r <= 5'h0; ana_neg_r <= 5'h0; ana_ref_r <= 4'h0;
      end else if (soft_reset_cmd && !prot_act) begin
         result_r <= 16'h0; irq_flag_reg_r <= 3'h0; irq_r <= 1'b0; dma_req_r <= 1'b0;
         evt_result_ready_flag_r <= 1'b0; unread_r <= 1'b0;
      end else begin
         ana_pos_r <= (cur_pos > `ADCW_MUXPOS_MAX) ? `ADCW_MUXPOS_MAX : cur_pos;
         ana_neg_r <= (s_neg > `ADCW_MUXNEG_MAX) ? `ADCW_MUXNEG_MAX : s_neg;
         ana_ref_r <= s_ref;
         if (fin) result_r <= fmt;                          // overwrite
         unread_r <= fin | (unread_r & ~result_rd);
         irq_flag_reg_r <= set_v | (irq_flag_reg_r & ~flag_clr);
         // level irq, wakes the system
         irq_r <= |((set_v | (irq_flag_reg_r & ~flag_clr)) & ien_r);
         dma_req_r <= fin | (dma_req_r & ~result_rd);
         evt_result_ready_flag_r <= fin;                               // event only, no wake
      end
   end
endmodule // adcw_ctrl

// ==== adcw_ctrl_props.sv ====
`timescale 1ns/10ps
`include "adcw_map.vh"
// -----------------------------------------
// port checker for the converter control block
// -----------------------------------------
module adcw_ctrl_props (
   input wire        clk_sys, rst_n, wr_cfg, wr_dbg, soft_reset_cmd, result_rd,
   input wire        protect_on, cpu_halted, cpu_rst_ext, ext_dbg_acc,
   input wire        ana_sample_r, irq_r, dma_req_r, evt_result_ready_flag_r, wr_refused_r,
   input wire        busy_r, dbg_run_r,
   input wire [2:0]  flag_clr, irq_flag_reg_r,
   input wire [4:0]  ana_pos_r, ana_neg_r,
   input wire [15:0] result_r
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // protection in force with no lifting condition
   wire prot = protect_on && !cpu_halted && !cpu_rst_ext && !ext_dbg_acc;
   // slack covers the 8 and 12 bit spans; an abort drops busy instead
   a_conv_len: assert property (ana_sample_r && !soft_reset_cmd |->
      ##[380:575] (evt_result_ready_flag_r || !busy_r)) else $error("conversion overran its span");
   a_result_cause: assert property ($changed(result_r) |-> evt_result_ready_flag_r || $past(soft_reset_cmd))
      else $error("result changed without a finish");
   a_overrun_set: assert property (evt_result_ready_flag_r && $past(dma_req_r) && !$past(result_rd) |-> irq_flag_reg_r[1])
      else $error("unread result overwritten without overrun");
   a_ready_flag: assert property (evt_result_ready_flag_r |-> irq_flag_reg_r[0] && dma_req_r)
      else $error("finish without ready flag or dma request");
   a_flag_sticky: assert property (irq_flag_reg_r[0] && !flag_clr[0] && !soft_reset_cmd |=> irq_flag_reg_r[0])
      else $error("ready flag lost without clear");
   a_dma_hold: assert property (dma_req_r && !result_rd && !soft_reset_cmd |=> dma_req_r)
      else $error("dma request dropped before read");
   a_refuse_pulse: assert property (prot && wr_cfg |=> wr_refused_r)
      else $error("protected write not refused");
   a_refuse_cause: assert property (wr_refused_r |-> $past(prot) && ($past(wr_cfg) || $past(wr_dbg) || $past(soft_reset_cmd)))
      else $error("refusal without protected write");
   a_mux_range: assert property (ana_pos_r <= `ADCW_MUXPOS_MAX && ana_neg_r <= `ADCW_MUXNEG_MAX)
      else $error("mux select beyond last source");
   a_debug_halt: assert property (cpu_halted && $past(cpu_halted) && !dbg_run_r |-> !ana_sample_r)
      else $error("conversion started while halted");
endmodule // adcw_ctrl_props

bind adcw_ctrl adcw_ctrl_props u_props (.*);

// ==== adcw_ana_model.sv ====
`timescale 1ns/10ps
// analog core stand-in: level is valid only while converting
module adcw_ana_model (
   input  wire        clk_sys,
   input  wire        busy_r,
   input  wire [11:0] level,
   output reg  [11:0] ana_data
);
   initial ana_data = 12'h000;
   // toggles when idle so stale data never looks valid
   always @(posedge clk_sys) begin
      if (busy_r)
         ana_data <= level;
      else
         ana_data <= ~ana_data;
   end
endmodule // adcw_ana_model

// ==== adc_control_wrapper_tb_top.sv ====
`timescale 1ns/10ps
module adc_control_wrapper_tb_top;
   // -----------------------------------------
   // stimulus, outputs and bookkeeping
   // -----------------------------------------
   reg         clk_sys, rst_n, wr_cfg, enable, left_adj, diff_mode, corr_en, result_rd;
   reg         debug_run_ctrl, wr_dbg, protect_on, cpu_halted, cpu_rst_ext, ext_dbg_acc;
   reg         start_cmd, start_evt, soft_reset_cmd, cl, cd;
   reg  [1:0]  res_sel, conv_mode, cr;
   reg  [2:0]  avg_log2, win_mode, irq_en, flag_clr;
   reg  [3:0]  ref_sel;
   reg  [4:0]  mux_pos, mux_neg, scan_count, win_chan;
   reg  [10:0] trim_val;
   reg  [11:0] gain_corr, offset_corr, level;
   reg  [15:0] win_lo, win_hi;
   reg  [63:0] rnd;
   wire        ana_sample_r, irq_r, dma_req_r, evt_result_ready_flag_r, wr_refused_r, busy_r, dbg_run_r;
   wire [2:0]  irq_flag_reg_r;
   wire [3:0]  ana_ref_r;
   wire [4:0]  ana_pos_r, ana_neg_r;
   wire [10:0] ana_trim_r;
   wire [11:0] ana_data;
   wire [15:0] result_r;
   int         n_fail = 0, compares = 0, i, n;

   adcw_ctrl dut (.*);
   adcw_ana_model u_ana (.*);

   initial begin
      clk_sys = 1'h0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // watchdog: the full run needs about a fifth of this span
   initial begin
      #200000;
      n_fail++;
      print_verdict;
   end

   task print_verdict;
      if (n_fail == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input [15:0] e, input [15:0] g);
      compares++;
      if (e !== g) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task tk(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   // top bits of the sample, sign extended in differential mode
   function [15:0] expv(input [11:0] a);
      int w;
      reg [15:0] v;
      w = (cr == 2'h0) ? 12 : (cr == 2'h2) ? 10 : 8;
      v = {4'h0, a} >> (12 - w);
      if (cd) begin
         v = v ^ (16'h1 << (w - 1));
         if (v[w-1]) v = v | (16'hffff << w);
      end
      expv = cl ? (v << (16 - w)) : v;
   endfunction
   task cfg(input e, input [1:0] r, input l, input d, input [1:0] m, input [1:0] lf);
      reg p;
      @(posedge clk_sys);
      rnd = {$urandom, $urandom};
      {mux_pos, mux_neg, ref_sel, avg_log2, gain_corr, offset_corr} <= rnd[40:0];
      {win_chan, win_lo, win_hi, trim_val} <= rnd[63:16];
      scan_count <= rnd[4:0] | 5'h01;
      win_mode <= rnd[2:0] % 3'h5;
      {enable, res_sel, left_adj, diff_mode, conv_mode} <= {e, r, l, d, m};
      {cpu_rst_ext, ext_dbg_acc} <= lf;
      wr_cfg <= 1'h1;
      p = protect_on && !cpu_halted && lf == 2'h0;
      if (!p) {cr, cl, cd} = {r, l, d};
      @(posedge clk_sys);
      wr_cfg <= 1'h0;
      #1;
      chk("refused", p, wr_refused_r);
      tk(4);
   endtask
   task wait_evt;
      n = 0;
      while (evt_result_ready_flag_r !== 1'h1 && n < 700) begin
         tk(1);
         n++;
      end
   endtask
   task conv(input ev);
      tk(2);
      @(posedge clk_sys);
      rnd = {$urandom, $urandom};
      level <= rnd[11:0];
      {start_evt, start_cmd} <= {ev, !ev};
      @(posedge clk_sys);
      {start_evt, start_cmd} <= 2'h0;
      #1;
      wait_evt;
      if (conv_mode == 2'h1)
         chk("latency", 16'h1, n < 700);
      else
         chk("latency", (cr == 2'h0) ? 16'h23c : (cr == 2'h2) ? 16'h1dd : 16'h17e, n);
      chk("result", expv(level), result_r);
      chk("ready", 16'h1, irq_flag_reg_r[0]);
   endtask
   task rd;
      @(posedge clk_sys);
      result_rd <= 1'h1;
      @(posedge clk_sys);
      result_rd <= 1'h0;
      #1;
      chk("dma_req", 16'h0, dma_req_r);
   endtask
   task clr;
      @(posedge clk_sys);
      flag_clr <= 3'h7;
      @(posedge clk_sys);
      flag_clr <= 3'h0;
      tk(2);
   endtask

   initial begin
      {rst_n, wr_cfg, enable, left_adj, diff_mode, corr_en, result_rd, debug_run_ctrl} = 8'h00;
      {wr_dbg, protect_on, cpu_halted, cpu_rst_ext, ext_dbg_acc, start_cmd, start_evt} = 7'h00;
      {soft_reset_cmd, res_sel, conv_mode, avg_log2, win_mode, flag_clr, ref_sel} = 18'h0;
      {mux_pos, mux_neg, scan_count, win_chan, trim_val, gain_corr, offset_corr} = 55'h0;
      {level, win_lo, win_hi, cr, cl, cd} = 48'h0;
      irq_en = 3'h3;
      rnd = {$urandom(32'hb0d2), $urandom};
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'h1;
      tk(1);
      chk("result", 16'h0, result_r);
      // the 12, 10 and 8 bit widths, both justifications, sign and both start sources
      for (i = 0; i < 6; i++) begin
         cfg(1'h1, (i < 2) ? 2'h0 : (i < 4) ? 2'h2 : 2'h3, i[0], i[1], 2'h0, 2'h0);
         conv(i[0]);
         chk("ref_sel", ref_sel, ana_ref_r);
         chk("trim", trim_val, ana_trim_r);
         rd;
      end
      // back-to-back results without a read
      clr;
      chk("irq", 16'h0, irq_r);
      conv(1'h0);
      conv(1'h1);
      chk("overrun", 16'h1, irq_flag_reg_r[1]);
      chk("irq", 16'h1, irq_r);
      rd;
      clr;
      chk("flags", 16'h0, irq_flag_reg_r);
      // refused write keeps the 8 bit setup, lifted writes land
      protect_on <= 1'h1;
      cfg(1'h1, 2'h0, 1'h0, 1'h0, 2'h0, 2'h0);
      conv(1'h0);
      rd;
      cfg(1'h1, 2'h0, 1'h1, 1'h0, 2'h0, 2'h1);
      cfg(1'h1, 2'h2, 1'h0, 1'h1, 2'h0, 2'h2);
      conv(1'h1);
      rd;
      // halted start ignored until forced to run
      @(posedge clk_sys);
      cpu_halted <= 1'h1;
      start_cmd <= 1'h1;
      @(posedge clk_sys);
      start_cmd <= 1'h0;
      {debug_run_ctrl, wr_dbg} <= 2'h3;
      tk(20);
      chk("halted busy", 16'h0, busy_r);
      chk("debug run", 16'h1, dbg_run_r);
      wr_dbg <= 1'h0;
      conv(1'h0);
      rd;
      {cpu_halted, protect_on} <= 2'h0;
      // free running, then scan
      for (i = 1; i < 3; i++) begin
         cfg(1'h1, 2'h3, 1'h0, 1'h0, i[1:0], 2'h0);
         conv(1'h0);
         rd;
         tk(1);
         wait_evt;
         chk("next result", 16'h1, n < 700);
         cfg(1'h0, 2'h3, 1'h0, 1'h0, i[1:0], 2'h0);
         tk(600);
         chk("stopped", 16'h0, busy_r);
      end
      @(posedge clk_sys);
      soft_reset_cmd <= 1'h1;
      @(posedge clk_sys);
      soft_reset_cmd <= 1'h0;
      tk(2);
      chk("result", 16'h0, result_r);
      chk("dma_req", 16'h0, dma_req_r);
      chk("debug run", 16'h1, dbg_run_r);
      print_verdict;
   end
endmodule // adc_control_wrapper_tb_top
